// >>> bench/fces_asserts.sv
// Purpose: port assertions for the erase-suspend command decoder
// Assumes: one clock, sync active-low reset
// Notes: bound after the module
`timescale 1ns/10ps
`include "fces_regs.vh"
module fces_chk #(
    parameter PARTS = 4,
    parameter PW = 2,
    parameter AW = 16
) (
    input wire clk_sys,
    input wire rst_b,
    input wire cmd_valid,
    input wire [7:0] cmd_data,
    input wire [AW-1:0] cmd_addr,
    input wire [PW-1:0] cmd_part,
    input wire engine_done,
    input wire [`FCES_ST_W-1:0] chip_state,
    input wire [2*PARTS-1:0] out_sel,
    input wire lock_error,
    input wire prog_error,
    input wire [1:0] lock_op,
    input wire lock_op_valid
);
    reg [PW-1:0] part_q;
    wire [13:0] st = chip_state;
    wire [7:0] d = cmd_data;
    wire w = cmd_valid;
    // ready, suspend, word- and buffered-program busy states
    wire run = |(st & 14'h061b);
    // setup, load, confirm, factory states
    wire frc = |(st & 14'h39e4);
    wire [1:0] sel = out_sel[2*part_q +: 2];
    always @(posedge clk_sys) part_q <= cmd_part;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // assertions
    wp_start_a: assert property (w && st[2] |=> st == `FCES_S_WP_BUSY)
        else $error("word setup stuck");
    busy_hold_a: assert property (w && (st[3] || st[9]) && d != 8'hb0 && !engine_done
        |=> $stable(st)) else $error("busy left");
    susp_entry_a: assert property (w && (st[3] || st[9]) && d == 8'hb0
        |=> st == ($past(st) << 1)) else $error("suspend not entered");
    susp_hold_a: assert property (w && (st[4] || st[10]) && d != 8'hd0
        && !engine_done |=> $stable(st)) else $error("suspend left");
    lock_ok_a: assert property (w && st[11] && d == 8'h01 |=> st == `FCES_S_ERS_SUSP
        ##[0:1] (lock_op_valid && lock_op == 2'h0)) else $error("lock missed");
    lock_err_a: assert property (w && st[11] && d == 8'hc0 |=> lock_error && st[1])
        else $error("lock error missed");
    stat_force_a: assert property (w && frc |=> sel == `FCES_OUT_STATUS)
        else $error("status not forced");
    rd_array_a: assert property (w && run && d == 8'hff |=> sel == `FCES_OUT_ARRAY)
        else $error("array not selected");
    sel_stat_a: assert property (w && run && d inside {8'h10, 8'h40, 8'he8, 8'h20, 8'h30,
        8'h70, 8'h60} |=> sel == `FCES_OUT_STATUS) else $error("status not selected");
    sel_keep_a: assert property (w && run && d inside {8'hd0, 8'hb0, 8'h50}
        |=> $stable(out_sel)) else $error("mux changed");
    clr_err_a: assert property (w && st[1] && d == 8'h50 |=> !lock_error && !prog_error)
        else $error("errors kept");
    cover property (w && st[11]);
    cover property (w && st[9]);
    cover property (w && st[13]);
    cover property (w && st[4]);
    cover property (w && st[10]);
endmodule
bind fces_cmd_decoder fces_chk #(.PARTS(PARTS), .PW(PW), .AW(AW)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_addr(cmd_addr), .cmd_part(cmd_part), .engine_done(engine_done),
    .chip_state(chip_state), .out_sel(out_sel), .lock_error(lock_error),
    .prog_error(prog_error), .lock_op(lock_op), .lock_op_valid(lock_op_valid));

// >>> bench/fces_host.sv
// Purpose: host model writing command bytes
// Assumes: lines change at the falling edge
// Notes: released data and address lines carry the inverse of the last value; cmd_part keeps its value
`timescale 1ns/10ps
module fces_host (
    input wire clk_sys,
    output reg cmd_valid,
    output reg [7:0] cmd_data,
    output reg [15:0] cmd_addr,
    output reg [1:0] cmd_part,
    output reg engine_done
);
    initial begin
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
        cmd_addr = 16'h0000;
        cmd_part = 2'h0;
        engine_done = 1'b0;
    end
    // one write, held through its sampling edge
    task wr(input [7:0] dv, input [15:0] av, input [1:0] pv);
        begin
            @(negedge clk_sys);
            cmd_valid = 1'b1;
            cmd_data = dv;
            cmd_addr = av;
            cmd_part = pv;
            @(posedge clk_sys);
            #1;
        end
    endtask
    task idle;
        begin
            @(negedge clk_sys);
            cmd_valid = 1'b0;
            cmd_data = ~cmd_data;
            cmd_addr = ~cmd_addr;
            @(posedge clk_sys);
            #1;
        end
    endtask
    // embedded operation completes
    task done;
        begin
            idle;
            @(negedge clk_sys);
            engine_done = 1'b1;
            @(negedge clk_sys);
            engine_done = 1'b0;
        end
    endtask
endmodule

// >>> bench/flash_cmd_state_erase_suspend_bench.sv
// Purpose: self-checking bench for the erase-suspend command decoder
// Assumes: host model drives all writes
// Notes: lock, word, buffered and factory sequences
`timescale 1ns/10ps
`include "fces_regs.vh"
module flash_cmd_state_erase_suspend_bench;
    localparam [15:0] BLK = 16'h0400;
    localparam [39:0] LK = 40'h012f03c055;
    localparam [79:0] MX = 80'h1040e820307060d050b0;
    reg clk_sys;
    reg rst_b;
    reg v;
    wire cmd_valid;
    wire [7:0] cmd_data;
    wire [15:0] cmd_addr;
    wire [1:0] cmd_part;
    wire engine_done;
    wire [13:0] chip_state;
    wire [7:0] out_sel;
    wire lock_error;
    wire prog_error;
    wire [1:0] lock_op;
    wire lock_op_valid;
    integer err_count;
    integer n_compared;
    integer i;
    fces_host h (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .cmd_addr(cmd_addr), .cmd_part(cmd_part), .engine_done(engine_done));
    fces_cmd_decoder DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_addr(cmd_addr), .cmd_part(cmd_part),
        .engine_done(engine_done), .chip_state(chip_state), .out_sel(out_sel),
        .lock_error(lock_error), .prog_error(prog_error), .lock_op(lock_op),
        .lock_op_valid(lock_op_valid));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function [1:0] sel(input [1:0] p);
        sel = out_sel[2*p +: 2];
    endfunction
    task wrap_up;
        begin
            if (err_count == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task cmp_st(input [13:0] got, input [13:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task cmp_v(input [1:0] got, input [1:0] exp);
        cmp_st({12'h0, got}, {12'h0, exp});
    endtask
    task cmp_b(input got, input exp);
        cmp_st({13'h0, got}, {13'h0, exp});
    endtask
    // ==========================================================
    // scenarios
    task lock_seq;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                h.wr(8'h60, BLK, 2'h0);
                cmp_v(sel(0), `FCES_OUT_STATUS);
                h.wr(LK[8*(4-i) +: 8], BLK, 2'h0);
                cmp_st(chip_state, `FCES_S_ERS_SUSP);
                v = lock_op_valid;
                h.idle;
                v = v | lock_op_valid;
                if (i < 3) begin
                    cmp_b(v, 1'b1);
                    cmp_v(lock_op, i[1:0]);
                end else
                    cmp_b(lock_error, 1'b1);
            end
            h.wr(8'h60, BLK, 2'h0);
            h.wr(8'hd0, BLK, 2'h0);
            cmp_v(lock_op, 2'h3);
            h.idle;
        end
    endtask
    task wp_mux;
        begin
            h.wr(8'h40, BLK, 2'h1);
            cmp_st(chip_state, `FCES_S_WP_SETUP);
            h.wr(8'h5a, BLK, 2'h1);
            cmp_v(sel(1), `FCES_OUT_STATUS);
            h.wr(8'hc0, BLK, 2'h2);
            cmp_st(chip_state, `FCES_S_WP_BUSY);
            for (i = 0; i < 10; i = i + 1) begin
                h.wr(8'hff, BLK, 2'h2);
                cmp_v(sel(2), `FCES_OUT_ARRAY);
                h.wr(MX[8*(9-i) +: 8], BLK, 2'h2);
                cmp_v(sel(2), i < 7 ? `FCES_OUT_STATUS : `FCES_OUT_ARRAY);
                cmp_st(chip_state, i < 9 ? `FCES_S_WP_BUSY : `FCES_S_WP_SUSP);
            end
            cmp_v(sel(1), `FCES_OUT_STATUS);
            cmp_b(lock_error, 1'b1);
            h.wr(8'hc0, BLK, 2'h2);
            cmp_st(chip_state, `FCES_S_WP_SUSP);
            h.wr(8'hd0, BLK, 2'h2);
            cmp_st(chip_state, `FCES_S_WP_BUSY);
            h.done;
            h.wr(8'h50, BLK, 2'h0);
            cmp_b(lock_error, 1'b0);
        end
    endtask
    task bp_seq;
        begin
            h.wr(8'he8, BLK, 2'h3);
            h.wr(8'h00, BLK, 2'h3);
            cmp_st(chip_state, `FCES_S_BP_LOAD1);
            h.wr(8'h01, BLK, 2'h3);
            h.wr(8'h11, BLK, 2'h3);
            cmp_st(chip_state, `FCES_S_BP_LOAD2);
            h.wr(8'h22, BLK, 2'h3);
            cmp_st(chip_state, `FCES_S_BP_CONF);
            h.wr(8'hd0, BLK, 2'h3);
            for (i = 0; i < 5; i = i + 1) begin
                h.wr(LK[8*(4-i) +: 8], BLK, 2'h3);
                cmp_st(chip_state, `FCES_S_BP_BUSY);
            end
            h.wr(8'hb0, BLK, 2'h3);
            h.wr(8'he8, BLK, 2'h3);
            cmp_st(chip_state, `FCES_S_BP_SUSP);
            h.wr(8'hd0, BLK, 2'h3);
            cmp_st(chip_state, `FCES_S_BP_BUSY);
            h.done;
            h.wr(8'he8, BLK, 2'h0);
            h.wr(8'h00, BLK, 2'h0);
            h.wr(8'h00, BLK, 2'h0);
            h.wr(8'h33, BLK, 2'h0);
            h.wr(8'hd0, 16'h0800, 2'h0);
            cmp_b(prog_error, 1'b1);
            h.wr(8'h30, BLK, 2'h0);
            h.wr(8'h12, BLK, 2'h0);
            h.wr(8'h34, BLK, 2'h0);
            cmp_st(chip_state, `FCES_S_FBP_BUSY);
            h.wr(8'h56, 16'h0800, 2'h0);
            cmp_st(chip_state, `FCES_S_READY);
            h.idle;
        end
    endtask
    initial begin
        err_count = 0;
        n_compared = 0;
        rst_b = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        cmp_st(chip_state, `FCES_S_ERS_SUSP);
        lock_seq;
        wp_mux;
        bp_seq;
        wrap_up;
    end
    initial begin
        #500000;
        err_count = err_count + 1;
        wrap_up;
    end
endmodule

// >>> design/fces_cmd_decoder.v
// Purpose: chip next-state and output-mux decoder for operations nested in erase suspend
// Assumes: cmd_valid is a one-cycle write strobe on clk_sys; engine_done from same clock
// Notes: states are the erase-suspend family plus factory-buffer-program mode
`timescale 1ns/10ps
`include "fces_regs.vh"

// How it works
// (R01) word-program setup in suspend goes busy; busy holds for all but B0H, even C0H
// (R02) nested word-program suspend holds for all setup and illegal codes; D0H confirm resumes busy
// (R03) nested buffered-program busy holds for every command write but B0H
// (R04) nested buffered-program suspend holds for every command write but D0H
// (R05) lock setup confirms lock, lock-down, config or D0H; C0H or illegal flags lock error
// (R06) setup, load, confirm and factory verify states force status output
// (R07) FFH from ready, suspended or word/buffered-program busy states selects array output
// (R08) 10H/40H, E8H, 20H, 30H from those states select status output
// (R09) D0H and B0H from those states leave output select unchanged
// (R10) 70H and 60H select status; 50H leaves output unchanged
// (R11) clear status resets error bits only while engine is idle
// (R12) each partition keeps its source; next state ignores the mux
// (R13) buffered setup takes block address, then word count, then loads data until count reached
// (R14) factory busy continues on setup block address, else back to ready
module fces_cmd_decoder #(
    parameter PARTS = 4,
    parameter PW = 2,
    parameter AW = 16
) (
    input wire clk_sys,
    input wire rst_b,
    input wire cmd_valid,
    input wire [7:0] cmd_data,
    input wire [AW-1:0] cmd_addr,
    input wire [PW-1:0] cmd_part,
    input wire engine_done,
    output wire [`FCES_ST_W-1:0] chip_state,
    output wire [2*PARTS-1:0] out_sel,
    output reg lock_error,
    output reg prog_error,
    output reg [1:0] lock_op,
    output reg lock_op_valid
);

    localparam S_READY = `FCES_S_READY;
    localparam S_ESUSP = `FCES_S_ERS_SUSP;
    localparam S_WPSET = `FCES_S_WP_SETUP;
    localparam S_WPBSY = `FCES_S_WP_BUSY;
    localparam S_WPSUS = `FCES_S_WP_SUSP;
    localparam S_BPSET = `FCES_S_BP_SETUP;
    localparam S_BPL1 = `FCES_S_BP_LOAD1;
    localparam S_BPL2 = `FCES_S_BP_LOAD2;
    localparam S_BPCNF = `FCES_S_BP_CONF;
    localparam S_BPBSY = `FCES_S_BP_BUSY;
    localparam S_BPSUS = `FCES_S_BP_SUSP;
    localparam S_LKSET = `FCES_S_LOCK_SETUP;
    localparam S_FBSET = `FCES_S_FBP_SETUP;
    localparam S_FBBSY = `FCES_S_FBP_BUSY;

    reg [`FCES_ST_W-1:0] state_q;
    reg [`FCES_ST_W-1:0] state_d;
    reg [8:0] count_q;
    reg [8:0] count_d;
    reg [AW-1:0] blk_q;
    reg [AW-1:0] blk_d;
    reg lock_err_d;
    reg prog_err_d;
    reg [1:0] lock_op_d;
    reg lock_op_valid_d;
    reg [1:0] sel_d;
    reg sel_keep;
    wire engine_busy;
    wire status_forced;

    // ==========================================================
    // state classes
    assign status_forced = (state_q == S_WPSET) | (state_q == S_BPSET) | (state_q == S_BPL1)
        | (state_q == S_BPL2) | (state_q == S_BPCNF) | (state_q == S_LKSET)
        | (state_q == S_FBSET) | (state_q == S_FBBSY);
    assign engine_busy = (state_q == S_WPBSY) | (state_q == S_BPBSY) | (state_q == S_FBBSY);
    assign chip_state = state_q;

    // ==========================================================
    // chip next state (mux select is never consulted)
    always @* begin
        state_d = state_q; // R12
        count_d = count_q;
        blk_d = blk_q;
        lock_err_d = lock_error;
        prog_err_d = prog_error;
        lock_op_d = lock_op;
        lock_op_valid_d = 1'b0;
        if (cmd_valid) begin
            case (state_q)
                S_ESUSP: begin
                    if (cmd_data == `FCES_CMD_WP_SETUP_A || cmd_data == `FCES_CMD_WP_SETUP_B)
                        state_d = S_WPSET;
                    else if (cmd_data == `FCES_CMD_BP_SETUP)
                        state_d = S_BPSET;
                    else if (cmd_data == `FCES_CMD_LOCK_SETUP)
                        state_d = S_LKSET;
                end
                S_READY: begin
                    if (cmd_data == `FCES_CMD_FBP_SETUP) begin
                        state_d = S_FBSET;
                        blk_d = cmd_addr;
                    end
                end
                S_WPSET: state_d = S_WPBSY; // R01
                S_WPBSY: begin
                    // suspend code is the only way into the nested suspend state
                    if (cmd_data == `FCES_CMD_SUSPEND)
                        state_d = S_WPSUS;
                    else
                        state_d = S_WPBSY; // R01
                end
                S_WPSUS: begin
                    if (cmd_data == `FCES_CMD_CONFIRM)
                        state_d = S_WPBSY;
                    else
                        state_d = S_WPSUS; // R02
                end
                S_BPSET: begin
                    state_d = S_BPL1; // R13
                    blk_d = cmd_addr;
                end
                S_BPL1: begin
                    count_d = {1'b0, cmd_data}; // R13
                    state_d = S_BPL2;
                end
                S_BPL2: begin
                    if (count_q == `FCES_CNT_ZERO)
                        state_d = S_BPCNF; // R13
                    else
                        count_d = count_q - `FCES_CNT_ONE;
                end
                S_BPCNF: begin
                    if (cmd_data == `FCES_CMD_CONFIRM && cmd_addr == blk_q)
                        state_d = S_BPBSY;
                    else begin
                        state_d = S_READY;
                        prog_err_d = 1'b1;
                    end
                end
                S_BPBSY: begin
                    if (cmd_data == `FCES_CMD_SUSPEND)
                        state_d = S_BPSUS;
                    else
                        state_d = S_BPBSY; // R03
                end
                S_BPSUS: begin
                    if (cmd_data == `FCES_CMD_CONFIRM)
                        state_d = S_BPBSY;
                    else
                        state_d = S_BPSUS; // R04
                end
                S_LKSET: begin
                    state_d = S_ESUSP; // R05
                    if (cmd_data == `FCES_CMD_LOCK_CONF || cmd_data == `FCES_CMD_LOCKDN_CONF
                        || cmd_data == `FCES_CMD_CR_CONF || cmd_data == `FCES_CMD_CONFIRM) begin
                        lock_op_d = (cmd_data == `FCES_CMD_LOCK_CONF) ? 2'h0 :
                            (cmd_data == `FCES_CMD_LOCKDN_CONF) ? 2'h1 :
                            (cmd_data == `FCES_CMD_CR_CONF) ? 2'h2 : 2'h3; // R05
                        lock_op_valid_d = 1'b1;
                    end else
                        lock_err_d = 1'b1; // R05
                end
                S_FBSET: begin
                    if (cmd_addr == blk_q)
                        state_d = S_FBBSY;
                    else begin
                        state_d = S_READY;
                        prog_err_d = 1'b1;
                    end
                end
                S_FBBSY: begin
                    if (cmd_addr != blk_q)
                        state_d = S_READY; // R14
                end
                default: state_d = S_READY;
            endcase
            if (cmd_data == `FCES_CMD_CLEAR_STATUS && !engine_busy && !status_forced) begin
                lock_err_d = 1'b0; // R11
                prog_err_d = 1'b0; // R11
            end
        end else if (engine_done && (state_q == S_WPBSY || state_q == S_BPBSY)) begin
            state_d = S_ESUSP;
        end else if (engine_done && state_q == S_FBBSY) begin
            state_d = S_READY;
        end
    end

    // ==========================================================
    // output mux next select for the addressed partition
    always @* begin
        sel_d = `FCES_OUT_STATUS;
        sel_keep = 1'b0;
        if (status_forced)
            sel_d = `FCES_OUT_STATUS; // R06
        else begin
            case (cmd_data)
                `FCES_CMD_READ_ARRAY: sel_d = `FCES_OUT_ARRAY; // R07
                `FCES_CMD_WP_SETUP_A, `FCES_CMD_WP_SETUP_B, `FCES_CMD_BP_SETUP,
                `FCES_CMD_ERASE_SETUP, `FCES_CMD_FBP_SETUP: sel_d = `FCES_OUT_STATUS; // R08
                `FCES_CMD_CONFIRM, `FCES_CMD_SUSPEND: sel_keep = 1'b1; // R09
                `FCES_CMD_READ_STATUS, `FCES_CMD_LOCK_SETUP: sel_d = `FCES_OUT_STATUS; // R10
                `FCES_CMD_CLEAR_STATUS: sel_keep = 1'b1; // R10
                `FCES_CMD_READ_ID_A, `FCES_CMD_READ_ID_B: sel_d = `FCES_OUT_ID;
                `FCES_CMD_OTP_SETUP: sel_d = `FCES_OUT_STATUS;
                default: sel_keep = 1'b1;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PARTS; gi = gi + 1) begin : g_part
            reg [1:0] sel_q;
            always @(posedge clk_sys) begin
                if (!rst_b)
                    sel_q <= `FCES_OUT_ARRAY;
                else if (cmd_valid && cmd_part == gi && !sel_keep)
                    sel_q <= sel_d; // R12
            end
            assign out_sel[2*gi+1:2*gi] = sel_q;
        end
    endgenerate

    // ==========================================================
    // registers
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= S_ESUSP;
            count_q <= `FCES_CNT_ZERO;
            blk_q <= {AW{1'b0}};
            lock_error <= 1'b0;
            prog_error <= 1'b0;
            lock_op <= 2'h0;
            lock_op_valid <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            blk_q <= blk_d;
            lock_error <= lock_err_d;
            prog_error <= prog_err_d;
            lock_op <= lock_op_d;
            lock_op_valid <= lock_op_valid_d;
        end
    end

endmodule

// >>> pkg/fces_regs.vh
// Purpose: command codes and state codes for the erase-suspend command decoder
// Assumes: 8-bit command bytes on the low data lane
// Notes: definitions only
`ifndef FCES_REGS_VH
`define FCES_REGS_VH

// ==========================================================
// command codes
`define FCES_CMD_READ_ARRAY 8'hff
`define FCES_CMD_WP_SETUP_A 8'h10
`define FCES_CMD_WP_SETUP_B 8'h40
`define FCES_CMD_BP_SETUP 8'he8
`define FCES_CMD_ERASE_SETUP 8'h20
`define FCES_CMD_FBP_SETUP 8'h30
`define FCES_CMD_CONFIRM 8'hd0
`define FCES_CMD_SUSPEND 8'hb0
`define FCES_CMD_READ_STATUS 8'h70
`define FCES_CMD_CLEAR_STATUS 8'h50
`define FCES_CMD_READ_ID_A 8'h90
`define FCES_CMD_READ_ID_B 8'h98
`define FCES_CMD_LOCK_SETUP 8'h60
`define FCES_CMD_OTP_SETUP 8'hc0
`define FCES_CMD_LOCK_CONF 8'h01
`define FCES_CMD_LOCKDN_CONF 8'h2f
`define FCES_CMD_CR_CONF 8'h03

// ==========================================================
// output source select
`define FCES_OUT_ARRAY 2'h0
`define FCES_OUT_STATUS 2'h1
`define FCES_OUT_ID 2'h2

// ==========================================================
// one-hot state codes
`define FCES_ST_W 14
`define FCES_S_READY 14'h0001
`define FCES_S_ERS_SUSP 14'h0002
`define FCES_S_WP_SETUP 14'h0004
`define FCES_S_WP_BUSY 14'h0008
`define FCES_S_WP_SUSP 14'h0010
`define FCES_S_BP_SETUP 14'h0020
`define FCES_S_BP_LOAD1 14'h0040
`define FCES_S_BP_LOAD2 14'h0080
`define FCES_S_BP_CONF 14'h0100
`define FCES_S_BP_BUSY 14'h0200
`define FCES_S_BP_SUSP 14'h0400
`define FCES_S_LOCK_SETUP 14'h0800
`define FCES_S_FBP_SETUP 14'h1000
`define FCES_S_FBP_BUSY 14'h2000

`define FCES_CNT_ONE 9'h001
`define FCES_CNT_ZERO 9'h000

`endif
